// ### tb.sv
// self-checking bench for the transceiver configuration latch bank
// assumes the bank and host model share clk; reset pulsed at start
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	error_cnt++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb import tcl_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic wr_en, rd_en;
	logic [NUM_CH-1:0] spd = 4'hf;
	logic [NUM_CH-1:0] txc = 4'h0;
	tcl_chan_out_t [NUM_CH-1:0] co;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] d;

	always #5 clk = ~clk;

	tcl_bank DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.channel_speed_select(spd), .tx_input_clock(txc), .chan_out(co));
	tcl_host_model host (.clk(clk), .rdata(rdata), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals();
		for (int c = 0; c < NUM_CH; c++) begin
			host.rd(4'(3*c), d); `CHK("rx static", RST_RXS, d)
			host.rd(4'(3*c+1), d); `CHK("tx static", RST_TXS, d)
			host.rd(4'(3*c+2), d); `CHK("dynamic", RST_DYN, d)
			`CHK("mult", MULT_BASE, co[c].tx_pll_multiplier)
			`CHK("reframe", 1'b1, co[c].reframe_enable)
			`CHK("rx power", 1'b0, co[c].rx_channel_power_enable)
			`CHK("rx bist", 1'b0, co[c].rx_selftest_active)
			`CHK("tx bist", 1'b0, co[c].tx_selftest_active)
			`CHK("drv1", 1'b0, co[c].primary_output_enable)
			`CHK("drv2", 1'b0, co[c].secondary_output_enable)
			`CHK("logic pd", 1'b1, co[c].channel_logic_powerdown)
			`CHK("rate", 1'b0, co[c].tx_pll_rate_select)
			`CHK("no combo", 1'b0, co[c].rate_reserved_combo)
			`CHK("src", 1'b1, co[c].tx_clock_source_select)
			`CHK("enc", 1'b1, co[c].tx_encoder_enable)
			`CHK("dec byp", 1'b1, co[c].decoder_bypass_select)
			`CHK("rx rate", 1'b1, co[c].rx_clock_rate_select)
			`CHK("rx src", 1'b1, co[c].rx_clock_source_select)
		end
		host.rd(4'hd, d); `CHK("global read", 8'h00, d)
		$display("test reset values done");
	endtask

	task automatic t_rate();
		host.wr(4'h1, 8'haf);
		`CHK("mult x20", MULT_DOUBLE, co[0].tx_pll_multiplier)
		`CHK("clk double", 1'b1, co[0].tx_clock_output_double)
		`CHK("dual edge", 1'b1, co[0].tx_dual_edge_capture)
		`CHK("rate on", 1'b1, co[0].tx_pll_rate_select)
		`CHK("combo off", 1'b0, co[0].rate_reserved_combo)
		host.wr(4'h1, RST_TXS);
		`CHK("mult x10", MULT_BASE, co[0].tx_pll_multiplier)
		`CHK("clk single", 1'b0, co[0].tx_clock_output_double)
		$display("test rate select done");
	endtask

	task automatic t_dynamic();
		host.wr(4'h5, 8'h4b);
		`CHK("reframe off", 1'b0, co[1].reframe_enable)
		`CHK("rx power on", 1'b1, co[1].rx_channel_power_enable)
		`CHK("rx bist on", 1'b1, co[1].rx_selftest_active)
		`CHK("tx bist on", 1'b1, co[1].tx_selftest_active)
		`CHK("drv2 on", 1'b1, co[1].secondary_output_enable)
		`CHK("drv1 off", 1'b0, co[1].primary_output_enable)
		`CHK("pd1", 1'b1, co[1].primary_driver_powerdown)
		`CHK("pd2", 1'b0, co[1].secondary_driver_powerdown)
		`CHK("logic on", 1'b0, co[1].channel_logic_powerdown)
		@(posedge clk);
		rst <= 1'b1;
		#1;
		`CHK("drv2 in reset", 1'b0, co[1].secondary_output_enable)
		@(posedge clk);
		rst <= 1'b0;
		host.rd(4'h5, d); `CHK("dyn after reset", RST_DYN, d)
		$display("test dynamic bank done");
	endtask

	task automatic t_phase();
		logic seen;
		seen = 1'b0;
		host.wr(4'h7, 8'ha9);
		host.wr(4'h8, 8'hb1);
		repeat (4) @(posedge clk);
		#1;
		// no transmit clock rise yet, so nothing may be re-centred
		`CHK("no rise", 1'b0, co[2].phase_buffer_recenter)
		host.rd(4'h8, d); `CHK("pending", 8'hb1, d)
		host.rd(4'hf, d); `CHK("status", 8'hf4, d)
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			txc[2] <= ~txc[2];
			#1;
			seen = seen | co[2].phase_buffer_recenter;
		end
		`CHK("recentred", 1'b1, seen)
		`CHK("released", 1'b0, co[2].phase_buffer_recenter)
		host.rd(4'h8, d); `CHK("self clear", 8'hb3, d)
		seen = 1'b0;
		host.wr(4'hb, 8'hb1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			seen = seen | co[3].phase_buffer_recenter;
		end
		`CHK("bypass none", 1'b0, seen)
		host.rd(4'hb, d); `CHK("bypass clear", 8'hb3, d)
		// channel A fields, then a bypassed re-centre with driver 1 on
		host.wr(4'h2, 8'h53);
		`CHK("reframe a", 1'b0, co[0].reframe_enable)
		`CHK("rx power a", 1'b1, co[0].rx_channel_power_enable)
		host.wr(4'h2, 8'hb5);
		`CHK("drv1 on", 1'b1, co[0].primary_output_enable)
		`CHK("logic a on", 1'b0, co[0].channel_logic_powerdown)
		repeat (2) @(posedge clk);
		host.rd(4'h2, d); `CHK("clear a", 8'hb7, d)
		host.wr(4'h8, 8'hb7);
		`CHK("pd2 c", 1'b1, co[2].secondary_driver_powerdown)
		`CHK("logic c on", 1'b0, co[2].channel_logic_powerdown)
		$display("test phase buffer reset done");
	endtask

	task automatic t_global();
		host.wr(4'h5, 8'hb2);
		host.wr(4'he, 8'hf6);
		host.rd(4'h2, d); `CHK("global on", 8'hf7, d)
		host.rd(4'h5, d); `CHK("global off", 8'hb2, d)
		host.wr(4'he, 8'hd7);
		host.rd(4'h5, d); `CHK("forced", 8'hd6, d)
		host.rd(4'hb, d); `CHK("forced d", 8'hd7, d)
		`CHK("forced rfen", 1'b1, co[1].reframe_enable)
		$display("test global writes done");
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		t_rate();
		t_dynamic();
		t_phase();
		t_global();
		complete_run();
	end
endmodule

// ### tcl_bank.sv
// configuration and control latch bank for four transceiver channels
// assumes a host on the plain strobe port and synchronous pin inputs
`timescale 1ns/1ns
module tcl_bank import tcl_pkg::*; (
	input logic clk, // 100 MHz system clock
	input logic rst, // device reset, synchronous, active high
	input logic [ADDR_W-1:0] addr, // latch address
	input logic [DATA_W-1:0] wdata, // write data
	input logic wr_en, // write strobe, one cycle
	input logic rd_en, // read strobe, one cycle
	output logic [DATA_W-1:0] rdata, // read data, cycle after rd_en
	input logic [NUM_CH-1:0] channel_speed_select, // per channel speed
	input logic [NUM_CH-1:0] tx_input_clock, // per channel tx clock
	output tcl_chan_out_t [NUM_CH-1:0] chan_out // per channel controls
);
	tcl_bank_state_t st_r;
	tcl_bank_state_t st_nxt;
	logic [NUM_CH-1:0] pbr_clear;
	logic [NUM_CH-1:0] pbr_busy;
	logic [NUM_CH-1:0] pbr_recenter;
	logic [NUM_CH-1:0] logic_pd;
	logic is_local;
	logic is_global;
	logic [ADDR_W-1:0] gkind;

	assign is_local = (addr < ADDR_GLOBAL_BASE);
	assign is_global = !is_local && (addr != ADDR_STATUS);
	assign gkind = addr - ADDR_GLOBAL_BASE;

	// ----------------------------------------------------------------
	// latch update and read-back
	// ----------------------------------------------------------------
	always_comb begin
		int idx;
		idx = 0;
		st_nxt = st_r;
		st_nxt.rdata = '0;
		// self clear is applied first so that a host write of 0 in the
		// same cycle still lands and starts a fresh re-centre
		for (int c = 0; c < NUM_CH; c++) begin
			if (pbr_clear[c]) begin
				idx = BANKS_PER_CH * c + BANK_DYN;
				st_nxt.latch[idx][DYN_PHASE_RST] = 1'b1; // R14
			end
		end
		if (wr_en) begin
			if (is_local) begin
				st_nxt.latch[addr] = wdata;
			end else if (is_global) begin
				for (int c = 0; c < NUM_CH; c++) begin
					idx = BANKS_PER_CH * c + int'(gkind);
					// the channel's own enable bit is never touched
					if (st_r.latch[idx][BIT_GLOBAL_EN] // R15
						|| wdata[BIT_FORCE_GLOBAL]) begin // R16
						st_nxt.latch[idx][7:1] = wdata[7:1];
					end
				end
			end
		end
		if (rd_en) begin
			if (is_local) begin
				st_nxt.rdata = st_r.latch[addr];
			end else if (addr == ADDR_STATUS) begin
				st_nxt.rdata = {logic_pd, pbr_busy};
			end else begin
				st_nxt.rdata = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '{latch: LATCH_RESET, rdata: 8'h00}; // R11
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;

	// ----------------------------------------------------------------
	// per-channel decode
	// ----------------------------------------------------------------
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			logic [7:0] rxs;
			logic [7:0] txs;
			logic [7:0] dyn;
			logic drv1_en;
			logic drv2_en;

			assign rxs = st_r.latch[BANKS_PER_CH * c + BANK_RXS];
			assign txs = st_r.latch[BANKS_PER_CH * c + BANK_TXS];
			assign dyn = st_r.latch[BANKS_PER_CH * c + BANK_DYN];
			// drivers drop at once while reset is held, not an edge later
			assign drv1_en = dyn[DYN_DRV1_EN] & ~rst; // R9 R11
			assign drv2_en = dyn[DYN_DRV2_EN] & ~rst; // R9 R11
			assign logic_pd[c] = ~drv1_en & ~drv2_en; // R10

			tcl_pbr_seq u_pbr (
				.clk(clk),
				.rst(rst),
				.tx_input_clock(tx_input_clock[c]),
				.request(~dyn[DYN_PHASE_RST]), // R12
				.bypass(txs[TXS_CKSEL]), // R20
				.recenter(pbr_recenter[c]),
				.clear(pbr_clear[c]),
				.busy(pbr_busy[c])
			);

			always_comb begin
				chan_out[c].tx_pll_rate_select = txs[TXS_RATE];
				chan_out[c].tx_pll_multiplier =
					txs[TXS_RATE] ? MULT_DOUBLE : MULT_BASE; // R1 R2
				chan_out[c].tx_clock_output_double = txs[TXS_RATE]; // R2
				chan_out[c].tx_dual_edge_capture = txs[TXS_RATE]; // R3
				chan_out[c].tx_clock_source_select = txs[TXS_CKSEL];
				chan_out[c].tx_encoder_enable = txs[TXS_ENC_EN];
				// host misuse is only flagged; the latch still takes it
				chan_out[c].rate_reserved_combo =
					txs[TXS_RATE] & ~channel_speed_select[c]; // R4
				chan_out[c].decoder_bypass_select = rxs[RXS_DEC_BYPASS];
				chan_out[c].rx_clock_rate_select = rxs[RXS_RATE];
				chan_out[c].rx_clock_source_select = rxs[RXS_CKSEL];
				chan_out[c].reframe_enable = dyn[DYN_REFRAME]; // R5
				chan_out[c].rx_channel_power_enable = dyn[DYN_RXPWR]; // R6
				chan_out[c].rx_selftest_active = ~dyn[DYN_RX_TEST]; // R7
				chan_out[c].tx_selftest_active = ~dyn[DYN_TX_TEST]; // R8
				chan_out[c].primary_output_enable = drv1_en;
				chan_out[c].secondary_output_enable = drv2_en;
				chan_out[c].primary_driver_powerdown = ~drv1_en; // R10
				chan_out[c].secondary_driver_powerdown = ~drv2_en; // R10
				chan_out[c].channel_logic_powerdown = logic_pd[c];
				chan_out[c].phase_buffer_recenter =
					pbr_recenter[c] & ~txs[TXS_CKSEL]; // R20
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks on all four channels and the shared write path
	// ----------------------------------------------------------------
	a_reset_drivers_off: assert property (@(posedge clk) // R11
		rst |-> (chan_out[0].primary_output_enable == 1'b0
			&& chan_out[3].secondary_output_enable == 1'b0))
		else $error("driver enabled during reset");
	a_reset_defaults: assert property (@(posedge clk) // R1
		rst |=> (chan_out[0].tx_pll_multiplier == 5'h0a
			&& chan_out[0].reframe_enable
			&& !chan_out[0].rx_channel_power_enable
			&& !chan_out[0].rx_selftest_active
			&& !chan_out[0].tx_selftest_active))
		else $error("channel defaults wrong after reset");
	a_rate_double: assert property (@(posedge clk) disable iff (rst) // R2
		(wr_en && addr == 4'h1 && wdata[TXS_RATE])
		|=> (chan_out[0].tx_pll_multiplier == 5'h14
			&& chan_out[0].tx_clock_output_double
			&& chan_out[0].tx_dual_edge_capture))
		else $error("rate select did not double the multiplier");
	a_reserved_flag: assert property (@(posedge clk) disable iff (rst) // R4
		(chan_out[1].tx_pll_rate_select && !channel_speed_select[1])
		|-> chan_out[1].rate_reserved_combo)
		else $error("reserved rate combination not flagged");
	a_dyn_fields: assert property (@(posedge clk) disable iff (rst) // R5
		(wr_en && addr == 4'h2 && !wdata[DYN_REFRAME] && wdata[DYN_RXPWR]
			&& !wdata[DYN_RX_TEST] && wdata[DYN_TX_TEST])
		|=> (!chan_out[0].reframe_enable
			&& chan_out[0].rx_channel_power_enable
			&& chan_out[0].rx_selftest_active
			&& !chan_out[0].tx_selftest_active))
		else $error("dynamic latch fields not decoded");
	a_tx_selftest: assert property (@(posedge clk) disable iff (rst) // R8
		(wr_en && addr == 4'h5 && !wdata[DYN_TX_TEST])
		|=> chan_out[1].tx_selftest_active)
		else $error("transmit self-test not enabled");
	a_logic_powerdown: assert property (@(posedge clk) disable iff (rst) // R10
		(wr_en && addr == 4'h8 && wdata[DYN_DRV1_EN] && !wdata[DYN_DRV2_EN])
		|=> (!chan_out[2].channel_logic_powerdown
			&& chan_out[2].secondary_driver_powerdown)
		##1 (!wr_en || addr != 4'h8) [*1]
		|-> !chan_out[2].channel_logic_powerdown)
		else $error("channel logic power state wrong");
	a_global_blocked: assert property (@(posedge clk) disable iff (rst) // R15
		(wr_en && addr == 4'he && !wdata[BIT_FORCE_GLOBAL]
			&& !st_r.latch[5][BIT_GLOBAL_EN])
		|=> st_r.latch[5][7:2] == $past(st_r.latch[5][7:2]))
		else $error("global write reached a disabled address");
	a_global_forced: assert property (@(posedge clk) disable iff (rst) // R16
		(wr_en && addr == 4'he && wdata[BIT_FORCE_GLOBAL])
		|=> (st_r.latch[2][7:2] == $past(wdata[7:2])
			&& st_r.latch[11][7:2] == $past(wdata[7:2])))
		else $error("forced global write missed a channel");
	a_self_clear: assert property (@(posedge clk) disable iff (rst) // R14
		(wr_en && addr == 4'h2 && !wdata[DYN_PHASE_RST]
			&& wdata[DYN_DRV1_EN] && st_r.latch[1][TXS_CKSEL])
		##1 (!wr_en || addr != 4'h2) [*2]
		|=> st_r.latch[2][DYN_PHASE_RST])
		else $error("phase reset latch did not clear itself");
	a_no_recenter_bypass: assert property (@(posedge clk) disable iff (rst)
		chan_out[0].tx_clock_source_select // R20
		|-> !chan_out[0].phase_buffer_recenter)
		else $error("re-centre while phase buffer bypassed");
	a_status_read: assert property (@(posedge clk) disable iff (rst) // R12
		(rd_en && addr == ADDR_STATUS && !st_r.latch[8][DYN_PHASE_RST])
		|=> rdata[2])
		else $error("pending phase reset not shown busy");
	a_primary_enable: assert property (@(posedge clk) disable iff (rst) // R9
		(wr_en && addr == 4'h2 && wdata[DYN_DRV1_EN])
		|=> chan_out[0].primary_output_enable)
		else $error("primary driver not enabled by its latch");
	a_rate_base: assert property (@(posedge clk) disable iff (rst) // R1
		(wr_en && addr == 4'h1 && !wdata[TXS_RATE])
		|=> (chan_out[0].tx_pll_multiplier == MULT_BASE
			&& !chan_out[0].tx_clock_output_double))
		else $error("rate select 0 did not restore the base multiplier");
	a_global_keeps_en: assert property (@(posedge clk) disable iff (rst) // R15
		(wr_en && is_global)
		|=> (st_r.latch[5][BIT_GLOBAL_EN]
			== $past(st_r.latch[5][BIT_GLOBAL_EN])))
		else $error("global write changed a per-address enable");
endmodule

// ### tcl_host_model.sv
// host controller model driving the latch bank's strobe port
// assumes one clock shared with the bank and read data one cycle late
`timescale 1ns/1ns
module tcl_host_model import tcl_pkg::*; (
	input wire logic clk, // system clock
	input wire logic [DATA_W-1:0] rdata, // read data from the bank
	output logic [ADDR_W-1:0] addr, // latch address
	output logic [DATA_W-1:0] wdata, // write data
	output logic wr_en, // write strobe
	output logic rd_en // read strobe
);
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// the caller keeps rate select at 0 while speed select is low
	// and configures static banks before the dynamic bank
	// and never moves a bypassed half-rate receiver live to decoding
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		// released data must not look like the last value
		wdata <= ~d;
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule

// ### tcl_pbr_seq.sv
// per-channel phase-buffer reset sequencer
// assumes tx_input_clock is sampled as a plain level on clk
`timescale 1ns/1ns
module tcl_pbr_seq import tcl_pkg::*; (
	input logic clk, // system clock
	input logic rst, // synchronous, active high
	input logic tx_input_clock, // channel transmit input clock level
	input logic request, // phase reset latch reads 0
	input logic bypass, // phase buffer bypassed
	output logic recenter, // level, buffer held re-centring
	output logic clear, // one cycle, sets the latch back to 1
	output logic busy // sequence pending or running
);
	tcl_pbr_state_t st_r;
	tcl_pbr_state_t st_nxt;
	logic tx_rise;

	assign tx_rise = tx_input_clock & ~st_r.tx_prev;

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.tx_prev = tx_input_clock;
		case (st_r.fsm)
			PBR_IDLE: begin
				if (request && bypass) begin
					st_nxt.fsm = PBR_CLEAR; // R20
				end else if (request && tx_rise) begin
					st_nxt.fsm = PBR_APPLY; // R13
				end
			end
			PBR_APPLY: begin
				if (tx_rise) begin
					st_nxt.fsm = PBR_CLEAR; // R21
				end
			end
			PBR_CLEAR: begin
				st_nxt.fsm = PBR_IDLE;
			end
			default: begin
				st_nxt.fsm = PBR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '{fsm: PBR_IDLE, tx_prev: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign recenter = (st_r.fsm == PBR_APPLY); // R12
	assign clear = (st_r.fsm == PBR_CLEAR); // R14
	assign busy = request | (st_r.fsm != PBR_IDLE);

	a_apply_on_edge: assert property (@(posedge clk) disable iff (rst) // R13
		(st_r.fsm == PBR_IDLE && request && !bypass && tx_rise) |=> recenter)
		else $error("re-centre not started on transmit clock rise");
	a_clear_after_edge: assert property (@(posedge clk) disable iff (rst) // R21
		(recenter && tx_rise) |=> clear ##1 !clear)
		else $error("self clear not one cycle after second rise");
	a_bypass_no_apply: assert property (@(posedge clk) disable iff (rst) // R20
		(st_r.fsm == PBR_IDLE && request && bypass) |=> clear && !recenter)
		else $error("bypassed buffer was re-centred");
	a_idle_no_apply: assert property (@(posedge clk) disable iff (rst) // R13
		(st_r.fsm == PBR_IDLE && !tx_rise) |=> !recenter)
		else $error("re-centre started without a transmit clock rise");
endmodule

// ### tcl_pkg.sv
// constants, field layout and carrier types of the transceiver config latches
// assumes one 100 MHz clock; every pin input is synchronous to it
//
// Notes on behaviour
// [R1] rate select resets to 0: pll multiplies by ten, clock output full rate
// [R2] rate select 1: pll multiplies by twenty, clock output twice reference
// [R3] rate select 1: transmit data captured on both reference clock edges
// [R4] host never sets rate select while channel speed select is low
// [R5] reframe enable resets to 1; at 0 framer never moves the offset
// [R6] receive power enable resets to 0; 0 powers pll and analogue down
// [R7] receive self-test latch active low, resets to 1 meaning disabled
// [R8] transmit self-test latch active low, resets to 1 meaning disabled
// [R9] primary and secondary driver enables reset to 0; 1 drives data
// [R10] disabled driver powers down; both disabled powers channel logic down
// [R11] device reset disables every serial output driver on all channels
// [R12] phase reset resets to 1; writing 0 re-centres the phase buffer
// [R13] phase reset request is sampled on each transmit input clock rise
// [R14] phase reset latch clears itself; host never writes 1 afterwards
// [R15] per-address global enable resets to 1; 0 blocks global writes
// [R16] force bit in a global write updates all channels regardless
// [R17] host pulses device reset and resets the test port after power-up
// [R18] host order: static receive, static transmit, dynamic, phase reset
// [R19] host never switches bypassed half-rate decoder to enabled live
// [R20] clock select 1 bypasses the phase buffer; no re-centre is needed
// [R21] latch returns to 1 on the transmit clock edge after re-centring
package tcl_pkg;
	localparam int NUM_CH = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_LATCH = 12;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_GLOBAL_BASE = 4'hc;
	localparam logic [3:0] ADDR_STATUS = 4'hf;
	localparam int BANK_RXS = 0;
	localparam int BANK_TXS = 1;
	localparam int BANK_DYN = 2;
	localparam int BANKS_PER_CH = 3;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_GLOBAL_EN = 0;
	localparam int BIT_FORCE_GLOBAL = 0;
	localparam int RXS_RATE = 1;
	localparam int RXS_CKSEL = 2;
	localparam int RXS_DEC_BYPASS = 3;
	localparam int TXS_RATE = 1;
	localparam int TXS_CKSEL = 2;
	localparam int TXS_ENC_EN = 3;
	localparam int DYN_PHASE_RST = 1;
	localparam int DYN_DRV1_EN = 2;
	localparam int DYN_DRV2_EN = 3;
	localparam int DYN_TX_TEST = 4;
	localparam int DYN_RX_TEST = 5;
	localparam int DYN_RXPWR = 6;
	localparam int DYN_REFRAME = 7;

	// ----------------------------------------------------------------
	// reset values and multipliers
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_RXS = 8'hbf;
	localparam logic [7:0] RST_TXS = 8'had;
	localparam logic [7:0] RST_DYN = 8'hb3;
	localparam logic [NUM_LATCH-1:0][7:0] LATCH_RESET =
		{NUM_CH{RST_DYN, RST_TXS, RST_RXS}};
	localparam logic [4:0] MULT_BASE = 5'h0a;
	localparam logic [4:0] MULT_DOUBLE = 5'h14;

	typedef enum logic [2:0] {
		PBR_IDLE = 3'b001,
		PBR_APPLY = 3'b010,
		PBR_CLEAR = 3'b100
	} tcl_pbr_fsm_t;

	typedef struct packed {
		tcl_pbr_fsm_t fsm;
		logic tx_prev;
	} tcl_pbr_state_t;

	typedef struct packed {
		logic [NUM_LATCH-1:0][7:0] latch;
		logic [7:0] rdata;
	} tcl_bank_state_t;

	typedef struct packed {
		logic tx_pll_rate_select;
		logic [4:0] tx_pll_multiplier;
		logic tx_clock_output_double;
		logic tx_dual_edge_capture;
		logic tx_clock_source_select;
		logic tx_encoder_enable;
		logic rate_reserved_combo;
		logic decoder_bypass_select;
		logic rx_clock_rate_select;
		logic rx_clock_source_select;
		logic reframe_enable;
		logic rx_channel_power_enable;
		logic rx_selftest_active;
		logic tx_selftest_active;
		logic primary_output_enable;
		logic secondary_output_enable;
		logic primary_driver_powerdown;
		logic secondary_driver_powerdown;
		logic channel_logic_powerdown;
		logic phase_buffer_recenter;
	} tcl_chan_out_t;
endpackage
